// ---- hw/ptp_event_trigger_pkg.sv ----
// Constants and types for the event capture and trigger configuration block.
// Assumes a 16-bit paged management register port and a 20 MHz reference clock.
`default_nettype none
package ptp_event_trigger_pkg;
    localparam int ADDR_W    = 5;
    localparam int DATA_W    = 16;
    localparam int NUM_UNITS = 8;
    localparam int NUM_PINS  = 12;
    localparam int SEL_W     = 3;
    localparam int PIN_W     = 4;

    localparam logic [4:0] PAGE_SELECT_ADDR        = 5'h13;
    localparam logic [4:0] TRIGGER_CONFIG_ADDR     = 5'h14;
    localparam logic [4:0] EVENT_CONFIG_ADDR       = 5'h15;
    localparam logic [4:0] EVENT_QUEUE_STATUS_ADDR = 5'h1E;
    localparam logic [4:0] EVENT_CAPTURE_DATA_ADDR = 5'h1F;
    localparam logic [2:0] PAGE_STATUS             = 3'h4;
    localparam logic [2:0] PAGE_CONFIG             = 3'h5;
    localparam logic [2:0] PAGE_RESET              = 3'h0;
    localparam logic [3:0] PIN_MAX                 = 4'hC;

    // Trigger and event configuration field positions
    localparam int OUT_PULSE_BIT    = 15;
    localparam int OUT_PERIODIC_BIT = 14;
    localparam int OUT_OVERDUE_BIT  = 13;
    localparam int OUT_REPORT_BIT   = 12;
    localparam int OUT_INVERT_BIT   = 7;
    localparam int CAP_RISE_BIT     = 14;
    localparam int CAP_FALL_BIT     = 13;
    localparam int CAP_ONCE_BIT     = 12;
    localparam int PIN_LSB          = 8;
    localparam int SEL_LSB          = 1;
    localparam int COMMIT_BIT       = 0;

    // Event queue status field positions
    localparam int ST_DET_BIT    = 0;
    localparam int ST_MULT_BIT   = 1;
    localparam int ST_NUM_LSB    = 2;
    localparam int ST_RF_BIT     = 5;
    localparam int ST_LEN_LSB    = 6;
    localparam int ST_MISSED_LSB = 8;
    localparam logic [1:0] TS_LEN_ALL = 2'h3;
    localparam logic [2:0] MISSED_MAX = 3'h7;

    // Trigger pulse width
    localparam int CLK_PERIOD_NS = 50;
    localparam int OUT_PULSE_MODE_NS = 100;
    localparam int OUT_PULSE_MODE_CYCLES = (OUT_PULSE_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {PH_EXT, PH_NS_LO, PH_NS_HI, PH_SEC_LO, PH_SEC_HI} data_phase_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] ext;
        logic        mult;
        logic [2:0]  num;
        logic        rf;
        logic [2:0]  missed;
        logic [29:0] ns;
        logic [31:0] sec;
    } event_rec_type;
endpackage
`default_nettype wire

// ---- hw/ptp_event_trigger_config.sv ----
// Event capture units, trigger generators and their paged configuration registers.
// Assumes a same-clock register master, a same-clock time counter and comparator,
// and asynchronous general-purpose pins that are synchronised here.
// Operation
// - Extended status odd bits give edge direction per unit, 1 rising.
// - Extended status even bits flag units that saw the edge.
// - Each event data read returns the next 16-bit piece, extended status or timestamp.
// - Trigger write with commit bit stores fields into selected trigger.
// - Trigger write without commit selects trigger for next read-back.
// - Pulse bit makes trigger emit a pulse, not an edge.
// - Periodic bit keeps trigger repeating; otherwise it fires once.
// - Overdue bit fires late trigger at once; late periodic fires without a done report.
// - Report bit flags completion or late error, and interrupts when enabled.
// - Non-zero pin field routes trigger to pins one through twelve.
// - Invert bit flips trigger output at trigger time.
// - Trigger select bits choose target of configuration access.
// - Trigger commit bit self-clears and reads as zero.
// - Reserved configuration bits ignore writes and read zero.
// - Event configuration uses same commit and read-back procedure.
// - Rise and fall enables capture matching edges on event input.
// - Single capture mode clears both enables after a capture.
// - Non-zero event pin field connects unit to pins one through twelve.
// - Event select chooses unit; commit bit stores its configuration.
// - Reading event status advances queue to next captured event.
// - With simultaneous events, extended status comes before timestamp pieces.
// - Pieces follow ns low, ns high with top bits zero, sec low, sec high.
`default_nettype none
module ptp_event_trigger_config #(
    parameter int PULSE_CYCLES = ptp_event_trigger_pkg::OUT_PULSE_MODE_CYCLES
) (
    // Clock and reset
    input  wire logic                                     ref_clk_i,
    input  wire logic                                     rstn_i,
    // Management register port
    input  wire logic [ptp_event_trigger_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [ptp_event_trigger_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                                     reg_wr_i,
    input  wire logic                                     reg_rd_i,
    output logic      [ptp_event_trigger_pkg::DATA_W-1:0] reg_rdata_o,
    // Time of day and trigger time comparison
    input  wire logic [29:0]                              time_ns_i,
    input  wire logic [31:0]                              time_sec_i,
    input  wire logic [ptp_event_trigger_pkg::NUM_UNITS-1:0] trig_match_i,
    input  wire logic [ptp_event_trigger_pkg::NUM_UNITS-1:0] trig_late_i,
    input  wire logic                                     trig_irq_en_i,
    // Trigger notification
    output logic      [ptp_event_trigger_pkg::NUM_UNITS-1:0] trig_done_o,
    output logic      [ptp_event_trigger_pkg::NUM_UNITS-1:0] trig_late_err_o,
    output logic                                          trig_irq_o,
    // General-purpose pins
    input  wire logic [ptp_event_trigger_pkg::NUM_PINS-1:0]  gpio_i,
    output logic      [ptp_event_trigger_pkg::NUM_PINS-1:0]  gpio_o,
    output logic      [ptp_event_trigger_pkg::NUM_PINS-1:0]  gpio_oe_o
);
    import ptp_event_trigger_pkg::*;

    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15) begin : g_bad_pulse
        $error("PULSE_CYCLES must lie between 1 and 15");
    end

    typedef struct packed {
        logic [2:0]                     page;
        logic [DATA_W-1:0]              rdata;
        logic [SEL_W-1:0]               out_unit_choice;
        logic [SEL_W-1:0]               evt_sel;
        logic [NUM_UNITS-1:0]           t_pulse;
        logic [NUM_UNITS-1:0]           t_per;
        logic [NUM_UNITS-1:0]           t_late;
        logic [NUM_UNITS-1:0]           t_notify;
        logic [NUM_UNITS-1:0]           t_toggle;
        logic [NUM_UNITS-1:0][PIN_W-1:0] t_pin;
        logic [NUM_UNITS-1:0]           t_armed;
        logic [NUM_UNITS-1:0]           t_level;
        logic [NUM_UNITS-1:0][3:0]      t_cnt;
        logic [NUM_UNITS-1:0]           t_done;
        logic [NUM_UNITS-1:0]           t_err;
        logic [NUM_UNITS-1:0]           e_rise_en;
        logic [NUM_UNITS-1:0]           e_fall_en;
        logic [NUM_UNITS-1:0]           e_once;
        logic [NUM_UNITS-1:0][PIN_W-1:0] e_pin;
        logic [NUM_PINS-1:0]            sync1;
        logic [NUM_PINS-1:0]            sync2;
        logic [NUM_PINS-1:0]            prev;
        event_rec_type                  pend;
        event_rec_type                  cur;
        data_phase_type                 phase;
        logic [NUM_PINS-1:0]            gpio;
        logic [NUM_PINS-1:0]            gpio_oe;
    } state_type;

    state_type s_reg;
    state_type s_next;

    logic                 cfg_page;
    logic                 sts_page;
    logic                 st_rd;
    logic                 ed_rd;
    logic [NUM_UNITS-1:0] rise_hit;
    logic [NUM_UNITS-1:0] fall_hit;
    logic [NUM_UNITS-1:0] hit;
    logic [NUM_UNITS-1:0] fire;
    event_rec_type        new_rec;

    assign cfg_page = (s_reg.page == PAGE_CONFIG);
    assign sts_page = (s_reg.page == PAGE_STATUS);
    assign st_rd    = reg_rd_i && sts_page && (reg_addr_i == EVENT_QUEUE_STATUS_ADDR);
    assign ed_rd    = reg_rd_i && sts_page && (reg_addr_i == EVENT_CAPTURE_DATA_ADDR);

    function automatic logic [DATA_W-1:0] status_word(input event_rec_type r);
        logic [DATA_W-1:0] w;
        w = '0;
        if (r.valid) begin
            w[ST_DET_BIT]                     = 1'b1;
            w[ST_MULT_BIT]                    = r.mult;
            w[ST_NUM_LSB +: 3]                = r.num;
            w[ST_RF_BIT]                      = r.rf;
            w[ST_LEN_LSB +: 2]                = TS_LEN_ALL;
            w[ST_MISSED_LSB +: 3]             = r.missed;
        end
        return w;
    endfunction

    always_comb begin
        logic [PIN_W-1:0] pin;
        logic             pin_ok;
        logic             cur_pin;
        logic             old_pin;
        pin     = '0;
        pin_ok  = 1'b0;
        cur_pin = 1'b0;
        old_pin = 1'b0;
        s_next  = s_reg;
        new_rec = '0;
        rise_hit = '0;
        fall_hit = '0;
        fire     = '0;

        // Pin synchroniser; the second stage and its delayed copy feed edge detection
        s_next.sync1 = gpio_i;
        s_next.sync2 = s_reg.sync1;
        s_next.prev  = s_reg.sync2;

        // Edge detection per event unit
        for (int i = 0; i < NUM_UNITS; i++) begin
            pin    = s_reg.e_pin[i];
            pin_ok = (pin != 4'h0) && (pin <= PIN_MAX);
            cur_pin = 1'b0;
            old_pin = 1'b0;
            for (int p = 0; p < NUM_PINS; p++) begin
                if (pin_ok && (pin == PIN_W'(p + 1))) begin
                    cur_pin = s_reg.sync2[p];
                    old_pin = s_reg.prev[p];
                end
            end
            rise_hit[i] = pin_ok && s_reg.e_rise_en[i] && cur_pin && !old_pin;
            fall_hit[i] = pin_ok && s_reg.e_fall_en[i] && !cur_pin && old_pin;
        end
        hit = rise_hit | fall_hit;

        // Build the captured record
        new_rec.valid = |hit;
        new_rec.mult  = (hit & (hit - NUM_UNITS'(1))) != '0;
        for (int i = NUM_UNITS - 1; i >= 0; i--) begin
            new_rec.ext[2*i+1] = rise_hit[i];
            new_rec.ext[2*i]   = hit[i];
            if (hit[i]) begin
                new_rec.num = SEL_W'(i);
                new_rec.rf  = rise_hit[i];
            end
        end
        new_rec.ns  = time_ns_i;
        new_rec.sec = time_sec_i;
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (s_reg.e_once[i] && hit[i]) begin
                s_next.e_rise_en[i] = 1'b0;
                s_next.e_fall_en[i] = 1'b0;
            end
        end

        // Queue: a status read moves the pending event to the visible slot
        if (st_rd) begin
            s_next.cur        = s_reg.pend;
            s_next.pend.valid = 1'b0;
            s_next.phase      = s_reg.pend.mult ? PH_EXT : PH_NS_LO;
        end
        // A capture in the same cycle as the read lands in the freed slot
        if (new_rec.valid) begin
            if (s_next.pend.valid) begin
                // Newer event is dropped so the older timestamp stays intact
                if (s_reg.pend.missed != MISSED_MAX) begin
                    s_next.pend.missed = s_reg.pend.missed + 3'h1;
                end
            end else begin
                s_next.pend = new_rec;
            end
        end

        // Trigger generators
        for (int i = 0; i < NUM_UNITS; i++) begin
            s_next.t_done[i] = 1'b0;
            s_next.t_err[i]  = 1'b0;
            fire[i] = s_reg.t_armed[i] && (trig_match_i[i] || (trig_late_i[i] && s_reg.t_late[i]));
            if (s_reg.t_cnt[i] != 4'h0) begin
                s_next.t_cnt[i] = s_reg.t_cnt[i] - 4'h1;
                if (s_reg.t_cnt[i] == 4'h1) begin
                    s_next.t_level[i] = 1'b0;
                end
            end
            if (fire[i]) begin
                if (s_reg.t_toggle[i]) begin
                    s_next.t_level[i] = !s_reg.t_level[i];
                end else if (s_reg.t_pulse[i]) begin
                    s_next.t_level[i] = 1'b1;
                    s_next.t_cnt[i]   = 4'(PULSE_CYCLES);
                end else begin
                    s_next.t_level[i] = 1'b1;
                end
                s_next.t_armed[i] = s_reg.t_per[i];
                // Late-started periodic output fires but reports no completion
                s_next.t_done[i] = s_reg.t_notify[i] &&
                                   !(s_reg.t_per[i] && trig_late_i[i] && !trig_match_i[i]);
            end else if (s_reg.t_armed[i] && trig_late_i[i] && !s_reg.t_late[i]) begin
                s_next.t_armed[i] = 1'b0;
                s_next.t_err[i]   = s_reg.t_notify[i];
            end
        end

        // Register writes
        s_next.rdata = '0;
        if (reg_wr_i) begin
            if (reg_addr_i == PAGE_SELECT_ADDR) begin
                s_next.page = reg_wdata_i[2:0];
            end else if (cfg_page && reg_addr_i == TRIGGER_CONFIG_ADDR) begin
                s_next.out_unit_choice = reg_wdata_i[SEL_LSB +: SEL_W];
                if (reg_wdata_i[COMMIT_BIT]) begin
                    for (int i = 0; i < NUM_UNITS; i++) begin
                        if (reg_wdata_i[SEL_LSB +: SEL_W] == SEL_W'(i)) begin
                            s_next.t_pulse[i]  = reg_wdata_i[OUT_PULSE_BIT];
                            s_next.t_per[i]    = reg_wdata_i[OUT_PERIODIC_BIT];
                            s_next.t_late[i]   = reg_wdata_i[OUT_OVERDUE_BIT];
                            s_next.t_notify[i] = reg_wdata_i[OUT_REPORT_BIT];
                            s_next.t_pin[i]    = reg_wdata_i[PIN_LSB +: PIN_W];
                            s_next.t_toggle[i] = reg_wdata_i[OUT_INVERT_BIT];
                            s_next.t_armed[i]  = 1'b1;
                            s_next.t_cnt[i]    = 4'h0;
                        end
                    end
                end
            end else if (cfg_page && reg_addr_i == EVENT_CONFIG_ADDR) begin
                s_next.evt_sel = reg_wdata_i[SEL_LSB +: SEL_W];
                if (reg_wdata_i[COMMIT_BIT]) begin
                    for (int i = 0; i < NUM_UNITS; i++) begin
                        if (reg_wdata_i[SEL_LSB +: SEL_W] == SEL_W'(i)) begin
                            s_next.e_rise_en[i] = reg_wdata_i[CAP_RISE_BIT];
                            s_next.e_fall_en[i] = reg_wdata_i[CAP_FALL_BIT];
                            s_next.e_once[i]    = reg_wdata_i[CAP_ONCE_BIT];
                            s_next.e_pin[i]     = reg_wdata_i[PIN_LSB +: PIN_W];
                        end
                    end
                end
            end
        end

        // Register reads; reserved and commit bits stay zero
        if (reg_rd_i) begin
            if (reg_addr_i == PAGE_SELECT_ADDR) begin
                s_next.rdata[2:0] = s_reg.page;
            end else if (cfg_page && reg_addr_i == TRIGGER_CONFIG_ADDR) begin
                s_next.rdata[OUT_PULSE_BIT]       = s_reg.t_pulse[s_reg.out_unit_choice];
                s_next.rdata[OUT_PERIODIC_BIT]    = s_reg.t_per[s_reg.out_unit_choice];
                s_next.rdata[OUT_OVERDUE_BIT]     = s_reg.t_late[s_reg.out_unit_choice];
                s_next.rdata[OUT_REPORT_BIT]      = s_reg.t_notify[s_reg.out_unit_choice];
                s_next.rdata[PIN_LSB +: PIN_W]    = s_reg.t_pin[s_reg.out_unit_choice];
                s_next.rdata[OUT_INVERT_BIT]      = s_reg.t_toggle[s_reg.out_unit_choice];
                s_next.rdata[SEL_LSB +: SEL_W]    = s_reg.out_unit_choice;
            end else if (cfg_page && reg_addr_i == EVENT_CONFIG_ADDR) begin
                s_next.rdata[CAP_RISE_BIT]        = s_reg.e_rise_en[s_reg.evt_sel];
                s_next.rdata[CAP_FALL_BIT]        = s_reg.e_fall_en[s_reg.evt_sel];
                s_next.rdata[CAP_ONCE_BIT]        = s_reg.e_once[s_reg.evt_sel];
                s_next.rdata[PIN_LSB +: PIN_W]    = s_reg.e_pin[s_reg.evt_sel];
                s_next.rdata[SEL_LSB +: SEL_W]    = s_reg.evt_sel;
            end else if (st_rd) begin
                s_next.rdata = status_word(s_reg.pend);
            end else if (ed_rd) begin
                case (s_reg.phase)
                    PH_EXT: begin
                        s_next.rdata = s_reg.cur.ext;
                        s_next.phase = PH_NS_LO;
                    end
                    PH_NS_LO: begin
                        s_next.rdata = s_reg.cur.ns[15:0];
                        s_next.phase = PH_NS_HI;
                    end
                    PH_NS_HI: begin
                        s_next.rdata = {2'b00, s_reg.cur.ns[29:16]};
                        s_next.phase = PH_SEC_LO;
                    end
                    PH_SEC_LO: begin
                        s_next.rdata = s_reg.cur.sec[15:0];
                        s_next.phase = PH_SEC_HI;
                    end
                    PH_SEC_HI: begin
                        s_next.rdata = s_reg.cur.sec[31:16];
                        s_next.phase = PH_NS_LO;
                    end
                    default: begin
                        s_next.phase = PH_NS_LO;
                    end
                endcase
            end
        end

        // Pin drive; the lowest trigger wins if two share a pin
        s_next.gpio    = '0;
        s_next.gpio_oe = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            for (int i = NUM_UNITS - 1; i >= 0; i--) begin
                if (s_reg.t_pin[i] == PIN_W'(p + 1)) begin
                    s_next.gpio_oe[p] = 1'b1;
                    s_next.gpio[p]    = s_next.t_level[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg       <= '0;
            s_reg.page  <= PAGE_RESET;
            s_reg.phase <= PH_NS_LO;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o     = s_reg.rdata;
    assign trig_done_o     = s_reg.t_done;
    assign trig_late_err_o = s_reg.t_err;
    assign trig_irq_o      = trig_irq_en_i && (|(s_reg.t_done | s_reg.t_err));
    assign gpio_o          = s_reg.gpio;
    assign gpio_oe_o       = s_reg.gpio_oe;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    chk_ext_dir_bits: assert property (new_rec.valid && !s_reg.pend.valid |=>
        s_reg.pend.ext[15] == $past(rise_hit[7]) && s_reg.pend.ext[1] == $past(rise_hit[0]))
        else $error("extended status direction bits wrong");
    chk_ext_seen_bits: assert property (new_rec.valid && !s_reg.pend.valid |=>
        s_reg.pend.ext[14] == $past(hit[7]) && s_reg.pend.ext[0] == $past(hit[0]))
        else $error("extended status seen bits wrong");
    chk_ns_high_piece: assert property (ed_rd && s_reg.phase == PH_NS_HI |=>
        reg_rdata_o[15:14] == 2'b00 && reg_rdata_o[13:0] == $past(s_reg.cur.ns[29:16]))
        else $error("nanosecond high piece wrong");
    chk_piece_advance: assert property (ed_rd && s_reg.phase == PH_NS_LO |=>
        s_reg.phase == PH_NS_HI ##0 reg_rdata_o == $past(s_reg.cur.ns[15:0]))
        else $error("timestamp piece did not advance");
    chk_commit_zero: assert property (reg_rd_i && cfg_page && reg_addr_i == TRIGGER_CONFIG_ADDR |=>
        reg_rdata_o[COMMIT_BIT] == 1'b0 && reg_rdata_o[6:4] == 3'h0)
        else $error("commit or reserved bits read nonzero");
    chk_event_reserved: assert property (reg_rd_i && cfg_page && reg_addr_i == EVENT_CONFIG_ADDR |=>
        reg_rdata_o[15] == 1'b0 && reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[0] == 1'b0)
        else $error("event reserved bits read nonzero");
    chk_once_clears: assert property ((|(hit & s_reg.e_once)) && !reg_wr_i |=>
        ((s_reg.e_rise_en | s_reg.e_fall_en) & $past(hit & s_reg.e_once)) == '0)
        else $error("single capture left enables set");
    chk_status_advance: assert property (st_rd && s_reg.pend.valid |=>
        s_reg.cur.valid && reg_rdata_o[ST_DET_BIT] && (!s_reg.pend.valid || $past(new_rec.valid)))
        else $error("status read did not advance queue");
    chk_ext_first: assert property (st_rd && s_reg.pend.valid && s_reg.pend.mult |=>
        s_reg.phase == PH_EXT && reg_rdata_o[ST_MULT_BIT])
        else $error("extended status not first");
    chk_late_silent: assert property (
        (|(s_reg.t_armed & s_reg.t_per & s_reg.t_late & trig_late_i & ~trig_match_i)) |=>
        (s_reg.t_done & $past(s_reg.t_armed & s_reg.t_per & s_reg.t_late & trig_late_i & ~trig_match_i)) == '0)
        else $error("late periodic trigger reported");
    chk_pin_unrouted: assert property (s_reg.t_pin == '0 |=> gpio_oe_o == '0)
        else $error("pin driven with no route");
    chk_pulse_high: assert property (fire[2] && s_reg.t_pulse[2] && !s_reg.t_toggle[2] && !reg_wr_i |=>
        s_reg.t_level[2] && s_reg.t_cnt[2] == 4'(PULSE_CYCLES))
        else $error("pulse did not start");
endmodule
`default_nettype wire

// ---- tb/pin_source_model.sv ----
// Far-side pin model: a bench-chosen level on each event pin, assumed to change off the clock edge.
`default_nettype none
module pin_source_model (
    input  wire logic [11:0] level_i,
    output logic      [11:0] pin_o
);
    timeunit 1ns / 1ns;
    assign pin_o = level_i;
endmodule
`default_nettype wire

// ---- tb/ptp_event_trigger_config_tb_top.sv ----
// Bench: register sequences for the event and trigger block, at a fixed time of day.
`default_nettype none
module ptp_event_trigger_config_tb_top;
    timeunit 1ns / 1ns;
    import ptp_event_trigger_pkg::*;
    localparam logic [4:0] PG = PAGE_SELECT_ADDR, TRG = TRIGGER_CONFIG_ADDR, EVT = EVENT_CONFIG_ADDR;
    localparam logic [4:0] STS = EVENT_QUEUE_STATUS_ADDR, DAT = EVENT_CAPTURE_DATA_ADDR;
    logic        ref_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [4:0]  reg_addr_i = '0;
    logic [7:0]  trig_match_i = '0, trig_late_i = '0, trig_done_o, trig_late_err_o;
    logic        irq_en = 1'b1, trig_irq_o;
    logic [15:0] reg_wdata_i = '0, reg_rdata_o;
    logic [11:0] gpio_i, gpio_o, gpio_oe_o, level = '0;
    int          n_fail = 0, n_tests = 0, n_hi = 0, n_done = 0, n_err = 0, n_irq = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) begin // Whole run: only trigger 2 drives pin 3
        n_hi   += int'(gpio_o[2] === 1'b1);
        n_done += int'((|trig_done_o) === 1'b1);
        n_err  += int'((|trig_late_err_o) === 1'b1);
        n_irq  += int'(trig_irq_o === 1'b1);
    end
    pin_source_model src (.level_i(level), .pin_o(gpio_i));
    ptp_event_trigger_config uut (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .time_ns_i(30'h2345_6789), .time_sec_i(32'h5A5A_C3C3), .trig_match_i, .trig_late_i,
        .trig_irq_en_i(irq_en), .trig_done_o, .trig_late_err_o, .trig_irq_o, .gpio_i, .gpio_o, .gpio_oe_o);
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        n_fail += int'(g !== e);
        if (g !== e) $display("Error %s expected %h seen %h", s, e, g);
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input string s = "");
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= w;
        reg_rd_i    <= !w;
        @(posedge ref_clk_i) {reg_wr_i, reg_rd_i} <= 2'h0;
        @(negedge ref_clk_i) if (!w) chk(s, d, reg_rdata_o);
        @(posedge ref_clk_i);
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200us n_fail++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        acc(1'b1, PG, 16'h0005);
        acc(1'b1, TRG, 16'hB375);
        acc(1'b1, TRG, 16'h0004);
        acc(1'b0, TRG, 16'hB304, "trigger_config");
        chk("pin enables", 16'h0004, {4'h0, gpio_oe_o});
        trig_match_i <= 8'h04;
        repeat (4) @(posedge ref_clk_i);
        trig_match_i <= 8'h00;
        acc(1'b1, EVT, 16'h2103);
        acc(1'b1, EVT, 16'hF1F1);
        acc(1'b1, EVT, 16'h0000);
        acc(1'b0, EVT, 16'h7100, "event_config");
        level <= 12'h001;
        repeat (8) @(posedge ref_clk_i);
        acc(1'b0, EVT, 16'h1100, "single capture");
        acc(1'b1, EVT, 16'h2101);
        acc(1'b1, PG, 16'h0004);
        acc(1'b0, STS, 16'h00E1, "status");
        acc(1'b0, DAT, 16'h6789, "ns low");
        acc(1'b0, DAT, 16'h2345, "ns high");
        acc(1'b0, DAT, 16'hC3C3, "sec low");
        acc(1'b0, DAT, 16'h5A5A, "sec high");
        level <= 12'h000;
        repeat (8) @(posedge ref_clk_i);
        acc(1'b0, STS, 16'h00C3, "multi status");
        acc(1'b0, DAT, 16'h0005, "extended status");
        chk("pulse cycles", 16'(OUT_PULSE_MODE_CYCLES), 16'(n_hi));
        acc(1'b1, PG, 16'h0005);
        acc(1'b1, TRG, 16'h7487);
        acc(1'b1, TRG, 16'h1009);
        trig_late_i <= 8'h18;
        @(posedge ref_clk_i) trig_late_i <= 8'h00;
        @(negedge ref_clk_i) chk("toggle on late", 16'h0008, {4'h0, gpio_o});
        @(posedge ref_clk_i) trig_match_i <= 8'h08;
        @(posedge ref_clk_i) trig_match_i <= 8'h00;
        @(negedge ref_clk_i) chk("toggle back", 16'h0000, {4'h0, gpio_o});
        @(posedge ref_clk_i) {trig_match_i, irq_en} <= {8'h08, 1'b0};
        @(posedge ref_clk_i) trig_match_i <= 8'h00;
        @(negedge ref_clk_i) chk("periodic repeat", 16'h0008, {4'h0, gpio_o});
        repeat (2) @(posedge ref_clk_i);
        chk("done pulses", 16'h0003, 16'(n_done));
        chk("late errors", 16'h0001, 16'(n_err));
        chk("interrupts", 16'h0003, 16'(n_irq));
        summarize();
    end
endmodule
`default_nettype wire
